// ==== hw/pwtm_pkg.sv ====
// Register map, field positions and reset values of the PWM timer control block
package pwtm_pkg;
  localparam int          PWTM_ADDR_W       = 8;
  localparam logic [7:0]  PWTM_OFF_START    = 8'h00;
  localparam logic [7:0]  PWTM_OFF_STATUS   = 8'h04;
  localparam logic [7:0]  PWTM_OFF_IRQ_REQ  = 8'h08;
  localparam logic [7:0]  PWTM_OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0]  PWTM_OFF_GEN_BASE = 8'h10;
  localparam logic [7:0]  PWTM_OFF_CNT0     = 8'h20;
  localparam logic [7:0]  PWTM_OFF_CNT1     = 8'h24;
  localparam int          PWTM_START_CNT0   = 0;
  localparam int          PWTM_START_CNT1   = 1;
  localparam int          PWTM_STAT_PERIOD  = 0;
  localparam int          PWTM_STAT_OVF     = 4;
  localparam int          PWTM_STAT_W       = 5;
  localparam int          PWTM_IRQ_BIT      = 1;
  localparam int          PWTM_NUM_GEN      = 4;
  localparam logic [1:0]  PWTM_RST_START    = 2'h0;
  localparam logic [4:0]  PWTM_RST_STATUS   = 5'h00;
  localparam logic [7:0]  PWTM_RST_IRQ_REQ  = 8'h00;
  localparam logic [7:0]  PWTM_RST_IRQ_MASK = 8'hff;
  localparam logic [7:0]  PWTM_REQ_RSVD0    = 8'h20;
  localparam logic [7:0]  PWTM_MASK_RSVD1   = 8'h20;
  localparam logic [1:0]  PWTM_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  PWTM_RESP_SLVERR  = 2'h2;
  localparam logic [3:0]  PWTM_SEL_NONE     = 4'h0;
  localparam logic [3:0]  PWTM_SEL_START    = 4'h1;
  localparam logic [3:0]  PWTM_SEL_STATUS   = 4'h2;
  localparam logic [3:0]  PWTM_SEL_IRQ_REQ  = 4'h3;
  localparam logic [3:0]  PWTM_SEL_IRQ_MASK = 4'h4;
  localparam logic [3:0]  PWTM_SEL_GEN      = 4'h5;
  localparam logic [3:0]  PWTM_SEL_CNT0     = 4'h6;
  localparam logic [3:0]  PWTM_SEL_CNT1     = 4'h7;
endpackage

// ==== hw/pwtm_cnt_if.sv ====
// Signals between the register side and the counter core
`timescale 1ns/10ps
interface pwtm_cnt_if #(parameter int W = 16);
  logic [1:0]        run;
  logic [3:0][W-1:0] cmp;
  logic [W-1:0]      cnt0;
  logic [W-1:0]      cnt1;
  logic [3:0]        match;
  logic              ovf;
  modport core (input run, input cmp, output cnt0, output cnt1, output match, output ovf);
  modport ctl  (output run, output cmp, input cnt0, input cnt1, input match, input ovf);
endinterface

// ==== hw/pwtm_counter_core.sv ====
// Two up counters; only counter 0 drives the compare-match and overflow pulses
`timescale 1ns/10ps
module pwtm_counter_core
  import pwtm_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic  clk_in,
  input  wire logic  rst_n_in,
  pwtm_cnt_if.core   cif
);
  typedef struct packed {
    logic [W-1:0] cnt0;
    logic [W-1:0] cnt1;
    logic [3:0]   match;
    logic         ovf;
  } pwtm_core_type;

  pwtm_core_type r_reg;
  pwtm_core_type r_next;

  always_comb begin
    r_next       = r_reg;
    r_next.match = 4'h0;
    r_next.ovf   = 1'b0;
    if (cif.run[PWTM_START_CNT0]) begin
      // Wrap at the period so counter 0 repeats every period
      if (r_reg.cnt0 == cif.cmp[0]) begin
        r_next.cnt0 = '0;
      end else begin
        r_next.cnt0 = r_reg.cnt0 + 1'b1;
      end
      r_next.ovf = (r_reg.cnt0 == '1);
      for (int i = 0; i < 4; i++) begin
        r_next.match[i] = (r_next.cnt0 == cif.cmp[i]);
      end
    end
    if (cif.run[PWTM_START_CNT1]) begin
      if (r_reg.cnt1 == cif.cmp[0]) begin
        r_next.cnt1 = '0;
      end else begin
        r_next.cnt1 = r_reg.cnt1 + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cif.cnt0  = r_reg.cnt0;
  assign cif.cnt1  = r_reg.cnt1;
  assign cif.match = r_reg.match;
  assign cif.ovf   = r_reg.ovf;
endmodule

// ==== hw/pwtm_top.sv ====
// PWM timer start control, match status and counter 0 interrupt request over AXI4-Lite
// How it works
// - Start bit 0 runs or stops counter 0
// - Start bit 1 runs or stops counter 1
// - Counter 0 equal to A0 sets flag
// - Flag clears by zero write after read
// - Status holds flags A-D, overflow, reserved
// - Request flag at bit 1 shows pending
// - Mask bit 1: zero enables, one disables
// - A0 holds period and compare value
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module pwtm_top
  import pwtm_pkg::*;
#(
  parameter int CNT_WIDTH = 16
) (
  input  wire logic                   CLK_IN,
  input  wire logic                   RST_N_IN,
  input  wire logic [PWTM_ADDR_W-1:0] AXI_AWADDR_IN,
  input  wire logic                   AXI_AWVALID_IN,
  output logic                        AXI_AWREADY_OUT,
  input  wire logic [31:0]            AXI_WDATA_IN,
  input  wire logic [3:0]             AXI_WSTRB_IN,
  input  wire logic                   AXI_WVALID_IN,
  output logic                        AXI_WREADY_OUT,
  output logic [1:0]                  AXI_BRESP_OUT,
  output logic                        AXI_BVALID_OUT,
  input  wire logic                   AXI_BREADY_IN,
  input  wire logic [PWTM_ADDR_W-1:0] AXI_ARADDR_IN,
  input  wire logic                   AXI_ARVALID_IN,
  output logic                        AXI_ARREADY_OUT,
  output logic [31:0]                 AXI_RDATA_OUT,
  output logic [1:0]                  AXI_RRESP_OUT,
  output logic                        AXI_RVALID_OUT,
  input  wire logic                   AXI_RREADY_IN,
  output logic                        IRQ_OUT
);
  if (CNT_WIDTH < 2 || CNT_WIDTH > 32) begin : g_chk
    $error("CNT_WIDTH must be 2 to 32");
  end

  typedef struct packed {
    logic                                  aw_have;
    logic [PWTM_ADDR_W-1:0]                aw_addr;
    logic                                  w_have;
    logic [31:0]                           w_data;
    logic [3:0]                            w_strb;
    logic                                  awready;
    logic                                  wready;
    logic                                  bvalid;
    logic [1:0]                            bresp;
    logic                                  arready;
    logic                                  rvalid;
    logic [31:0]                           rdata;
    logic [1:0]                            rresp;
    logic [1:0]                            start;
    logic [PWTM_STAT_W-1:0]                status;
    logic [PWTM_STAT_W-1:0]                armed;
    logic [7:0]                            irq_req;
    logic [7:0]                            irq_mask;
    logic [PWTM_NUM_GEN-1:0][CNT_WIDTH-1:0] gen;
    logic                                  irq;
  } pwtm_state_type;

  pwtm_state_type r_reg;
  pwtm_state_type r_next;

  pwtm_cnt_if #(.W(CNT_WIDTH)) cif ();

  pwtm_counter_core #(.W(CNT_WIDTH)) u_core (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .cif      (cif.core)
  );

  // Address decode shared by the read and write paths
  function automatic logic [3:0] pwtm_sel(input logic [PWTM_ADDR_W-1:0] addr);
    logic [3:0] sel;
    sel = PWTM_SEL_NONE;
    if (addr == PWTM_OFF_START) begin
      sel = PWTM_SEL_START;
    end else if (addr == PWTM_OFF_STATUS) begin
      sel = PWTM_SEL_STATUS;
    end else if (addr == PWTM_OFF_IRQ_REQ) begin
      sel = PWTM_SEL_IRQ_REQ;
    end else if (addr == PWTM_OFF_IRQ_MASK) begin
      sel = PWTM_SEL_IRQ_MASK;
    end else if (addr[7:4] == PWTM_OFF_GEN_BASE[7:4] && addr[1:0] == 2'h0) begin
      sel = PWTM_SEL_GEN;
    end else if (addr == PWTM_OFF_CNT0) begin
      sel = PWTM_SEL_CNT0;
    end else if (addr == PWTM_OFF_CNT1) begin
      sel = PWTM_SEL_CNT1;
    end
    return sel;
  endfunction

  logic [3:0] wr_sel;
  logic [3:0] rd_sel;
  logic [1:0] wr_gen;
  logic [1:0] rd_gen;
  logic       do_wr;
  logic       do_rd;
  logic       running;

  assign wr_sel  = pwtm_sel(r_reg.aw_addr);
  assign rd_sel  = pwtm_sel(AXI_ARADDR_IN);
  assign wr_gen  = r_reg.aw_addr[3:2];
  assign rd_gen  = AXI_ARADDR_IN[3:2];
  assign do_wr   = r_reg.aw_have && r_reg.w_have && !r_reg.bvalid;
  assign do_rd   = AXI_ARVALID_IN && r_reg.arready;
  assign running = (r_reg.start == 2'h3);

  always_comb begin
    r_next = r_reg;
    // Address and data are taken independently, in either order
    if (AXI_AWVALID_IN && r_reg.awready) begin
      r_next.aw_have = 1'b1;
      r_next.aw_addr = AXI_AWADDR_IN;
    end
    if (AXI_WVALID_IN && r_reg.wready) begin
      r_next.w_have = 1'b1;
      r_next.w_data = AXI_WDATA_IN;
      r_next.w_strb = AXI_WSTRB_IN;
    end
    if (r_reg.bvalid && AXI_BREADY_IN) begin
      r_next.bvalid = 1'b0;
    end
    if (do_wr) begin
      r_next.aw_have = 1'b0;
      r_next.w_have  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = (wr_sel == PWTM_SEL_NONE) ? PWTM_RESP_SLVERR : PWTM_RESP_OKAY;
      unique case (wr_sel)
        PWTM_SEL_START: begin
          if (r_reg.w_strb[0]) begin
            r_next.start = r_reg.w_data[1:0];
          end
        end
        PWTM_SEL_STATUS: begin
          // Only flags seen as 1 by the last read may be cleared
          if (r_reg.w_strb[0]) begin
            for (int i = 0; i < PWTM_STAT_W; i++) begin
              if (r_reg.armed[i] && !r_reg.w_data[i]) begin
                r_next.status[i] = 1'b0;
              end
            end
          end
          r_next.armed = '0;
        end
        PWTM_SEL_IRQ_REQ: begin
          if (r_reg.w_strb[0]) begin
            r_next.irq_req = r_reg.w_data[7:0] & ~PWTM_REQ_RSVD0;
          end
        end
        PWTM_SEL_IRQ_MASK: begin
          if (r_reg.w_strb[0]) begin
            r_next.irq_mask = r_reg.w_data[7:0] | PWTM_MASK_RSVD1;
          end
        end
        PWTM_SEL_GEN: begin
          // Writes are dropped only while both counters run (start bits 3), so the compare cannot tear then
          if (!running) begin
            for (int b = 0; b < 4; b++) begin
              if (r_reg.w_strb[b] && b * 8 < CNT_WIDTH) begin
                for (int k = 0; k < 8; k++) begin
                  if (b * 8 + k < CNT_WIDTH) begin
                    r_next.gen[wr_gen][b * 8 + k] = r_reg.w_data[b * 8 + k];
                  end
                end
              end
            end
          end
        end
        PWTM_SEL_CNT0,
        PWTM_SEL_CNT1,
        PWTM_SEL_NONE: begin
        end
        default: begin
        end
      endcase
    end
    if (r_reg.rvalid && AXI_RREADY_IN) begin
      r_next.rvalid = 1'b0;
    end
    if (do_rd) begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = (rd_sel == PWTM_SEL_NONE) ? PWTM_RESP_SLVERR : PWTM_RESP_OKAY;
      r_next.rdata  = 32'h0;
      unique case (rd_sel)
        PWTM_SEL_START: begin
          r_next.rdata = {30'h0, r_reg.start};
        end
        PWTM_SEL_STATUS: begin
          r_next.rdata = {27'h0, r_reg.status};
          r_next.armed = r_reg.status;
        end
        PWTM_SEL_IRQ_REQ: begin
          r_next.rdata = {24'h0, r_reg.irq_req};
        end
        PWTM_SEL_IRQ_MASK: begin
          r_next.rdata = {24'h0, r_reg.irq_mask};
        end
        PWTM_SEL_GEN: begin
          r_next.rdata = 32'(r_reg.gen[rd_gen]);
        end
        PWTM_SEL_CNT0: begin
          r_next.rdata = 32'(cif.cnt0);
        end
        PWTM_SEL_CNT1: begin
          r_next.rdata = 32'(cif.cnt1);
        end
        PWTM_SEL_NONE: begin
        end
        default: begin
        end
      endcase
    end
    // Hardware sets come last so an event beats a same-cycle clear
    for (int i = 0; i < 4; i++) begin
      if (cif.match[i]) begin
        r_next.status[i] = 1'b1;
      end
    end
    if (cif.ovf) begin
      r_next.status[PWTM_STAT_OVF] = 1'b1;
    end
    if (cif.match[0]) begin
      r_next.irq_req[PWTM_IRQ_BIT] = 1'b1;
    end
    r_next.irq     = r_next.irq_req[PWTM_IRQ_BIT] && !r_next.irq_mask[PWTM_IRQ_BIT];
    r_next.awready = !r_next.aw_have && !r_next.bvalid;
    r_next.wready  = !r_next.w_have && !r_next.bvalid;
    r_next.arready = !r_next.rvalid;
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      r_reg          <= '0;
      r_reg.start    <= PWTM_RST_START;
      r_reg.status   <= PWTM_RST_STATUS;
      r_reg.irq_req  <= PWTM_RST_IRQ_REQ;
      r_reg.irq_mask <= PWTM_RST_IRQ_MASK;
      r_reg.gen      <= '1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cif.run         = r_reg.start;
  assign cif.cmp         = r_reg.gen;
  assign AXI_AWREADY_OUT = r_reg.awready;
  assign AXI_WREADY_OUT  = r_reg.wready;
  assign AXI_BVALID_OUT  = r_reg.bvalid;
  assign AXI_BRESP_OUT   = r_reg.bresp;
  assign AXI_ARREADY_OUT = r_reg.arready;
  assign AXI_RVALID_OUT  = r_reg.rvalid;
  assign AXI_RDATA_OUT   = r_reg.rdata;
  assign AXI_RRESP_OUT   = r_reg.rresp;
  assign IRQ_OUT         = r_reg.irq;

  a_cnt0_stop: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !r_reg.start[0] |=> $stable(cif.cnt0))
    else $error("counter 0 moved while stopped");
  a_cnt1_stop: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (!r_reg.start[1] ##1 !r_reg.start[1]) |=> $stable(cif.cnt1))
    else $error("counter 1 moved while stopped");
  a_cnt0_runs: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (r_reg.start[0] && cif.cnt0 != r_reg.gen[0] && $stable(r_reg.start)) |=> cif.cnt0 == $past(cif.cnt0) + 1'b1)
    else $error("counter 0 did not advance toward period");
  a_match_sets: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (r_reg.start[0] && cif.cnt0 == r_reg.gen[0]) |-> ##[0:1] r_reg.status[PWTM_STAT_PERIOD])
    else $error("period match flag not set");
  a_flag_sticky: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (r_reg.status[0] && !(do_wr && wr_sel == PWTM_SEL_STATUS && r_reg.armed[0])) |=> r_reg.status[0])
    else $error("period match flag dropped without armed clear");
  a_rsvd_zero: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (do_rd && rd_sel == PWTM_SEL_STATUS) |=> AXI_RVALID_OUT && AXI_RDATA_OUT[31:5] == 27'h0)
    else $error("status reserved bits not zero");
  a_req_raise: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    cif.match[0] |=> r_reg.irq_req[PWTM_IRQ_BIT])
    else $error("request flag not raised on period match");
  a_mask_gate: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    r_reg.irq_mask[PWTM_IRQ_BIT] |-> !IRQ_OUT)
    else $error("interrupt passed a set mask");
  a_irq_follow: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (cif.match[0] && !r_reg.irq_mask[PWTM_IRQ_BIT] && !(do_wr && wr_sel == PWTM_SEL_IRQ_MASK)) |=> IRQ_OUT)
    else $error("unmasked period match gave no interrupt");
endmodule

// ==== testbench/pwtm_top_test.sv ====
// Self-checking bench for the PWM timer control block over AXI4-Lite
`timescale 1ns/10ps
module pwtm_top_test
  import pwtm_pkg::*;
;
  localparam int          CW      = 8;
  localparam logic [31:0] A0_ONES = 32'hffffffff >> (32 - CW);
  logic        clk_in;
  logic        rst_n_in;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        irq;
  logic [1:0]  b_q[$];
  logic [33:0] r_q[$];
  int          err_total;
  int          samples_checked;
  int          cycles;
  logic [31:0] seed;
  logic [7:0]  rv;
  logic [7:0]  mv;

  pwtm_top #(.CNT_WIDTH(CW)) DUT (
    .CLK_IN(clk_in), .RST_N_IN(rst_n_in),
    .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
    .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
    .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
    .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
    .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready),
    .IRQ_OUT(irq)
  );

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Readies are registered, so sampling at the falling edge is race free
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    @(posedge clk_in);
    b_q.push_back(er);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge clk_in);
      aw_ok = awvalid && awready;
      w_ok  = wvalid && wready;
      b_ok  = bvalid && bready;
      @(posedge clk_in);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_ok;
    logic r_ok;
    @(posedge clk_in);
    r_q.push_back({er, ed});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge clk_in);
      ar_ok = arvalid && arready;
      r_ok  = rvalid && rready;
      @(posedge clk_in);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) rready <= 1'b0;
    end
  endtask

  // Request output is registered on the same edge as the flag registers
  task automatic irq_chk(input logic e);
    @(posedge clk_in);
    @(negedge clk_in);
    chk({33'h0, irq}, {33'h0, e});
  endtask

  task automatic tdone(input string s);
    $display("test %s finished at %0t", s, $time);
  endtask

  // Result watcher: answers are taken in handshake order
  always @(posedge clk_in) begin
    if (bvalid && bready && b_q.size() > 0) begin
      chk({32'h0, bresp}, {32'h0, b_q.pop_front()});
    end
    if (rvalid && rready && r_q.size() > 0) begin
      chk({rresp, rdata}, r_q.pop_front());
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    err_total = 0; samples_checked = 0; cycles = 0; seed = 32'ha4d2bd97;
    rst_n_in = 1'b0; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0;
    wvalid = 1'b0; bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(PWTM_OFF_START, 32'h0, PWTM_RESP_OKAY);
    rd(PWTM_OFF_STATUS, 32'h0, PWTM_RESP_OKAY);
    rd(PWTM_OFF_IRQ_REQ, 32'h0, PWTM_RESP_OKAY);
    rd(PWTM_OFF_IRQ_MASK, 32'hff, PWTM_RESP_OKAY);
    rd(PWTM_OFF_GEN_BASE, A0_ONES, PWTM_RESP_OKAY);
    rd(PWTM_OFF_CNT0, 32'h0, PWTM_RESP_OKAY);
    rd(8'h30, 32'h0, PWTM_RESP_SLVERR);
    wr(8'h30, 32'h1, PWTM_RESP_SLVERR);
    irq_chk(1'b0);
    tdone("reset values");
    // Counter 1 alone must leave counter 0 and its flag untouched
    wr(PWTM_OFF_START, 32'h2, PWTM_RESP_OKAY);
    repeat (20) @(posedge clk_in);
    rd(PWTM_OFF_CNT0, 32'h0, PWTM_RESP_OKAY);
    rd(PWTM_OFF_STATUS, 32'h0, PWTM_RESP_OKAY);
    wr(PWTM_OFF_START, 32'h0, PWTM_RESP_OKAY);
    rd(PWTM_OFF_START, 32'h0, PWTM_RESP_OKAY);
    // Counter 1 ran for 30 edges between the two start writes
    rd(PWTM_OFF_CNT1, 32'h1e, PWTM_RESP_OKAY);
    tdone("start bits");
    // Start sequence with a short period
    wr(PWTM_OFF_GEN_BASE, 32'h5, PWTM_RESP_OKAY);
    wr(PWTM_OFF_IRQ_REQ, 32'h0, PWTM_RESP_OKAY);
    wr(PWTM_OFF_IRQ_MASK, 32'h0, PWTM_RESP_OKAY);
    rd(PWTM_OFF_IRQ_MASK, {24'h0, PWTM_MASK_RSVD1}, PWTM_RESP_OKAY);
    rd(PWTM_OFF_STATUS, 32'h0, PWTM_RESP_OKAY);
    wr(PWTM_OFF_STATUS, 32'h0, PWTM_RESP_OKAY);
    wr(PWTM_OFF_START, 32'h3, PWTM_RESP_OKAY);
    wr(PWTM_OFF_GEN_BASE, 32'h3, PWTM_RESP_OKAY);
    for (int n = 0; n < 50 && irq !== 1'b1; n++) @(negedge clk_in);
    chk({33'h0, irq}, {33'h0, 1'b1});
    rd(PWTM_OFF_STATUS, 32'h1, PWTM_RESP_OKAY);
    wr(PWTM_OFF_START, 32'h0, PWTM_RESP_OKAY);
    rd(PWTM_OFF_GEN_BASE, 32'h5, PWTM_RESP_OKAY);
    // Move the period out of reach so a stopped count cannot match again
    wr(PWTM_OFF_GEN_BASE, A0_ONES, PWTM_RESP_OKAY);
    tdone("period match");
    wr(PWTM_OFF_STATUS, 32'hff, PWTM_RESP_OKAY);
    wr(PWTM_OFF_STATUS, 32'h0, PWTM_RESP_OKAY);
    rd(PWTM_OFF_STATUS, 32'h1, PWTM_RESP_OKAY);
    wr(PWTM_OFF_STATUS, 32'h0, PWTM_RESP_OKAY);
    rd(PWTM_OFF_STATUS, 32'h0, PWTM_RESP_OKAY);
    wr(PWTM_OFF_IRQ_REQ, 32'h0, PWTM_RESP_OKAY);
    irq_chk(1'b0);
    tdone("flag clear");
    for (int i = 0; i < 6; i++) begin
      rv = 8'($random(seed));
      mv = 8'($random(seed));
      wr(PWTM_OFF_IRQ_REQ, {24'h0, rv}, PWTM_RESP_OKAY);
      wr(PWTM_OFF_IRQ_MASK, {24'h0, mv}, PWTM_RESP_OKAY);
      rd(PWTM_OFF_IRQ_REQ, {24'h0, rv & ~PWTM_REQ_RSVD0}, PWTM_RESP_OKAY);
      rd(PWTM_OFF_IRQ_MASK, {24'h0, mv | PWTM_MASK_RSVD1}, PWTM_RESP_OKAY);
      irq_chk(rv[PWTM_IRQ_BIT] & ~mv[PWTM_IRQ_BIT]);
    end
    tdone("request and mask");
    // Counter 0 alone through a full wrap: all compares hit all ones, then overflow
    wr(PWTM_OFF_START, 32'h1, PWTM_RESP_OKAY);
    repeat (300) @(posedge clk_in);
    wr(PWTM_OFF_START, 32'h0, PWTM_RESP_OKAY);
    rd(PWTM_OFF_STATUS, 32'h1f, PWTM_RESP_OKAY);
    tdone("overflow");
    repeat (4) @(posedge clk_in);
    wrap_up();
  end
endmodule
